// File: common/tsc_map.svh
// Offsets, field positions, reset values and timing counts of the time stamp counter
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH

// Register byte offsets on the Wishbone slave
`define TSC_OFS_CTRL 8'h00
`define TSC_OFS_STATUS 8'h04
`define TSC_OFS_MASK 8'h08
`define TSC_OFS_COUNT 8'h0C

// Control register fields
`define TSC_CTRL_MODE_LSB 0
`define TSC_CTRL_MODE_MSB 3
`define TSC_CTRL_MCLR_BIT 4

// Status and mask fields
`define TSC_EVT_OVF_BIT 0
`define TSC_EVT_TRIG_BIT 1

// Reset values
`define TSC_RST_MODE 4'h0
`define TSC_RST_EVT 2'h0

// Selector settings that bound the groups
`define TSC_SET_CLEAR_LAST 4'h4
`define TSC_SET_GATE_FIRST 4'h5
`define TSC_SET_GATE_LAST 4'h9
`define TSC_SET_COUNT 4'hF

// Module clock period and time bases
`define TSC_CLK_NS 10
`define TSC_TB0_NS 100
`define TSC_TB1_NS 1000
`define TSC_TB2_NS 10000
`define TSC_TB3_NS 100000
`define TSC_TB4_NS 1000000
`define TSC_NS2CYC(ns) (((ns) + `TSC_CLK_NS - 1) / `TSC_CLK_NS)

`endif

// File: common/tsc_pkg.sv
// Types shared by the time stamp counter modules
package tsc_pkg;

  // Behaviour group chosen by the front selector
  typedef enum logic [3:0] {
    GRP_CLEAR = 4'b0001,
    GRP_GATE = 4'b0010,
    GRP_COUNT = 4'b0100,
    GRP_IDLE = 4'b1000
  } mode_grp_t;

  // Raw trigger sources as they arrive
  typedef struct packed {
    logic ext_n;
    logic ext;
    logic mon;
  } trig_in_t;

  // Sticky event bits, same layout for status and mask
  typedef struct packed {
    logic trig;
    logic ovf;
  } evt_t;

endpackage

// File: src/trigger_combiner.sv
// Polarity correction and merging of the three trigger sources
module trigger_combiner (
  input wire logic clk_i,
  input wire logic rst_i,
  input tsc_pkg::trig_in_t trig_i,
  output logic trig_o
);

  // Pure gates: the external lines see no extra register stage
  assign trig_o = ~trig_i.ext_n | trig_i.ext | trig_i.mon; // [RL5] [RL6] [RL7] [RL15]

  property p_low_asserts;
    @(posedge clk_i) disable iff (rst_i) !trig_i.ext_n |-> trig_o;
  endproperty
  a_low_asserts: assert property (p_low_asserts) else $error("low external trigger not seen"); // [RL6]

  property p_high_asserts;
    @(posedge clk_i) disable iff (rst_i) trig_i.ext |-> trig_o;
  endproperty
  a_high_asserts: assert property (p_high_asserts) else $error("high external trigger not seen"); // [RL7]

  property p_idle;
    @(posedge clk_i) disable iff (rst_i) (trig_i.ext_n && !trig_i.ext && !trig_i.mon) |-> !trig_o;
  endproperty
  a_idle: assert property (p_idle) else $error("trigger set with all sources idle"); // [RL15]

endmodule // trigger_combiner

// File: src/tick_prescaler.sv
// Divides the module clock down to one of five time-base ticks
module tick_prescaler #(
  parameter int CW = 20,
  parameter int P0 = 10,
  parameter int P1 = 100,
  parameter int P2 = 1000,
  parameter int P3 = 10000,
  parameter int P4 = 100000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] sel_i,
  output logic tick_o
);

  logic [CW-1:0] div_q;
  logic [CW-1:0] div_d;
  logic [2:0] sel_q;
  logic tick_q;
  logic wrap;

  // Last count of the divider for a time base index
  function automatic logic [CW-1:0] last_of(input logic [2:0] s);
    case (s)
      3'h0: last_of = CW'(P0 - 1);
      3'h1: last_of = CW'(P1 - 1);
      3'h2: last_of = CW'(P2 - 1);
      3'h3: last_of = CW'(P3 - 1);
      default: last_of = CW'(P4 - 1);
    endcase
  endfunction

  // Restart on a new base so a switch never waits out the old long period
  assign wrap = (div_q >= last_of(sel_i)) || (sel_i != sel_q);
  assign div_d = wrap ? '0 : CW'(div_q + 1'b1);
  assign tick_o = tick_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_q <= '0;
      sel_q <= 3'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      sel_q <= sel_i;
      tick_q <= (div_q >= last_of(sel_i)) && (sel_i == sel_q); // [RL14]
    end
  end

  property p_tick_gap;
    @(posedge clk_i) disable iff (rst_i) tick_o |=> !tick_o;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("time base ticks back to back"); // [RL14]

endmodule // tick_prescaler

// File: src/time_stamp_counter.sv
// Time stamp counter with selector modes, trigger inputs, trace stamp and Wishbone registers
//
// Contract
// RL1 - Gated settings count ticks only while triggered
// RL2 - Highest setting per group is slowest base
// RL3 - Overflow in time modes lights overflow indicator
// RL4 - Cleared settings: any trigger zeroes the counter
// RL5 - External triggers act directly, like monitor trigger
// RL6 - First external trigger is active low
// RL7 - Second external trigger is active high
// RL8 - Counting setting counts pulses, ignores time base
// RL9 - Setting 5 uses a 0.1 us base
// RL10 - Operator clears counter before range measurement
// RL11 - Counter value accompanies every traced bus cycle
// RL12 - Setting 1 uses a 1 us base
// RL13 - Pulse setting counts each trigger rising edge
// RL14 - Time modes add one per selected tick
// RL15 - Sources ORed after polarity into one trigger
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`include "tsc_map.svh"

module time_stamp_counter #(
  parameter int CNT_W = 24,
  parameter int TB0_CYC = `TSC_NS2CYC(`TSC_TB0_NS),
  parameter int TB1_CYC = `TSC_NS2CYC(`TSC_TB1_NS),
  parameter int TB2_CYC = `TSC_NS2CYC(`TSC_TB2_NS),
  parameter int TB3_CYC = `TSC_NS2CYC(`TSC_TB3_NS),
  parameter int TB4_CYC = `TSC_NS2CYC(`TSC_TB4_NS)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic monitor_trig_i,
  input wire logic ext_trig_n_i,
  input wire logic ext_trig_i,
  input wire logic trace_strobe_i,
  output logic [CNT_W-1:0] trace_stamp_o,
  output logic trace_valid_o,
  output logic overflow_led_o,
  output logic irq_o
);

  logic [3:0] mode_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  tsc_pkg::evt_t status_q;
  tsc_pkg::evt_t status_d;
  tsc_pkg::evt_t mask_q;
  tsc_pkg::evt_t events;
  tsc_pkg::evt_t w1c;
  tsc_pkg::trig_in_t trig_raw;
  tsc_pkg::mode_grp_t grp;
  logic trig_q;
  logic trig_lvl;
  logic trig_rise;
  logic tick;
  logic [2:0] tb_idx;
  logic inc;
  logic clr;
  logic man_clr;
  logic cnt_max;
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_data;
  logic [CNT_W-1:0] stamp_q;
  logic stamp_vld_q;
  logic req;
  logic wr_en;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;

  // Map a selector setting onto its behaviour group
  function automatic tsc_pkg::mode_grp_t grp_of(input logic [3:0] m);
    if (m <= `TSC_SET_CLEAR_LAST)
      grp_of = tsc_pkg::GRP_CLEAR;
    else if (m <= `TSC_SET_GATE_LAST)
      grp_of = tsc_pkg::GRP_GATE;
    else if (m == `TSC_SET_COUNT)
      grp_of = tsc_pkg::GRP_COUNT;
    else
      grp_of = tsc_pkg::GRP_IDLE;
  endfunction

  // Time base index, 0 fastest to 4 slowest, for a selector setting
  function automatic logic [2:0] tb_of(input logic [3:0] m);
    logic [3:0] r;
    r = 4'h0;
    if (m <= `TSC_SET_CLEAR_LAST)
      r = m;
    else if (m <= `TSC_SET_GATE_LAST)
      r = 4'(m - `TSC_SET_GATE_FIRST);
    else
      r = 4'h0;
    tb_of = r[2:0];
  endfunction

  assign grp = grp_of(mode_q);
  assign tb_idx = tb_of(mode_q); // [RL2] [RL9] [RL12]

  // Trigger sources into one level
  assign trig_raw.ext_n = ext_trig_n_i;
  assign trig_raw.ext = ext_trig_i;
  assign trig_raw.mon = monitor_trig_i;

  trigger_combiner u_trig (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .trig_i(trig_raw),
    .trig_o(trig_lvl)
  );

  tick_prescaler #(
    .CW(20),
    .P0(TB0_CYC),
    .P1(TB1_CYC),
    .P2(TB2_CYC),
    .P3(TB3_CYC),
    .P4(TB4_CYC)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(tb_idx),
    .tick_o(tick)
  );

  // Edge seen in the cycle the level rises, so the direct path adds no delay
  assign trig_rise = trig_lvl & ~trig_q; // [RL13]

  // Bus decode; writes land on the edge where the master sees ack
  assign req = cyc_i & stb_i;
  assign wr_en = req & we_i & ack_q & sel_i[0];
  assign wr_ctrl = wr_en & (adr_i == `TSC_OFS_CTRL);
  assign wr_status = wr_en & (adr_i == `TSC_OFS_STATUS);
  assign wr_mask = wr_en & (adr_i == `TSC_OFS_MASK);
  assign man_clr = wr_ctrl & dat_i[`TSC_CTRL_MCLR_BIT];

  // Per-group increment and clear terms
  assign clr = (grp == tsc_pkg::GRP_CLEAR) & trig_rise; // [RL4]
  assign inc = ((grp == tsc_pkg::GRP_CLEAR) & tick & ~trig_rise) // [RL14]
             | ((grp == tsc_pkg::GRP_GATE) & tick & trig_lvl) // [RL1]
             | ((grp == tsc_pkg::GRP_COUNT) & trig_rise); // [RL8] [RL13]
  assign cnt_max = &cnt_q;
  // Counter wraps past its top; in the time groups the sticky flag is what tells software, a pulse-count wrap sets none
  assign cnt_d = (man_clr | clr) ? '0 : (inc ? CNT_W'(cnt_q + 1'b1) : cnt_q);

  // Events; overflow only matters where the count is a time
  assign events.ovf = inc & cnt_max & ~man_clr & (grp != tsc_pkg::GRP_COUNT); // [RL3]
  assign events.trig = trig_rise;
  assign w1c = wr_status ? tsc_pkg::evt_t'(dat_i[`TSC_EVT_TRIG_BIT:`TSC_EVT_OVF_BIT]) : '0;
  // A new event beats a clear written in the same cycle
  assign status_d = (status_q & ~w1c) | events;

  // Read data selection; unmapped offsets read zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (adr_i)
      `TSC_OFS_CTRL: rd_data[`TSC_CTRL_MODE_MSB:`TSC_CTRL_MODE_LSB] = mode_q;
      `TSC_OFS_STATUS: rd_data[`TSC_EVT_TRIG_BIT:`TSC_EVT_OVF_BIT] = status_q;
      `TSC_OFS_MASK: rd_data[`TSC_EVT_TRIG_BIT:`TSC_EVT_OVF_BIT] = mask_q;
      `TSC_OFS_COUNT: rd_data[CNT_W-1:0] = cnt_q;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Counter, trigger history and event registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= '0;
      trig_q <= 1'b0;
      status_q <= `TSC_RST_EVT;
    end
    else
    begin
      cnt_q <= cnt_d;
      trig_q <= trig_lvl;
      status_q <= status_d;
    end
  end

  // Software-written settings
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_q <= `TSC_RST_MODE;
      mask_q <= `TSC_RST_EVT;
    end
    else
    begin
      if (wr_ctrl)
        mode_q <= dat_i[`TSC_CTRL_MODE_MSB:`TSC_CTRL_MODE_LSB];
      if (wr_mask)
        mask_q <= tsc_pkg::evt_t'(dat_i[`TSC_EVT_TRIG_BIT:`TSC_EVT_OVF_BIT]);
    end
  end

  // One-wait-state ack; read data captured with it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q)
        dat_q <= rd_data;
    end
  end

  // Stamp taken in the traced cycle itself, before this edge's update
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stamp_q <= '0;
      stamp_vld_q <= 1'b0;
    end
    else
    begin
      stamp_vld_q <= trace_strobe_i;
      if (trace_strobe_i)
        stamp_q <= cnt_q; // [RL11]
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign trace_stamp_o = stamp_q;
  assign trace_valid_o = stamp_vld_q;
  assign overflow_led_o = status_q.ovf; // [RL3]
  assign irq_o = |(status_q & mask_q);

  sequence s_gate_closed;
    (grp == tsc_pkg::GRP_GATE) && !trig_lvl && !man_clr;
  endsequence

  sequence s_count_rise;
    (grp == tsc_pkg::GRP_COUNT) && trig_rise && !man_clr;
  endsequence

  property p_gate_hold;
    @(posedge clk_i) disable iff (rst_i) s_gate_closed |=> $stable(cnt_q);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gated count moved with trigger low"); // [RL1]

  property p_tick_step;
    @(posedge clk_i) disable iff (rst_i)
      ((grp == tsc_pkg::GRP_GATE) && trig_lvl && tick && !man_clr) |=> cnt_q == CNT_W'($past(cnt_q) + 1'b1);
  endproperty
  a_tick_step: assert property (p_tick_step) else $error("gated tick did not add one"); // [RL14]

  property p_clear_zero;
    @(posedge clk_i) disable iff (rst_i) ((grp == tsc_pkg::GRP_CLEAR) && trig_rise) |=> cnt_q == '0;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("trigger did not zero the count"); // [RL4]

  property p_ovf_led;
    @(posedge clk_i) disable iff (rst_i)
      ((grp != tsc_pkg::GRP_COUNT) && inc && cnt_max && !man_clr) |=> overflow_led_o && cnt_q == '0;
  endproperty
  a_ovf_led: assert property (p_ovf_led) else $error("overflow not indicated"); // [RL3]

  property p_pulse_step;
    @(posedge clk_i) disable iff (rst_i) s_count_rise |=> cnt_q == CNT_W'($past(cnt_q) + 1'b1);
  endproperty
  a_pulse_step: assert property (p_pulse_step) else $error("trigger pulse not counted"); // [RL13]

  property p_pulse_no_tb;
    @(posedge clk_i) disable iff (rst_i)
      ((grp == tsc_pkg::GRP_COUNT) && !trig_rise && !man_clr) |=> $stable(cnt_q);
  endproperty
  a_pulse_no_tb: assert property (p_pulse_no_tb) else $error("count moved without a pulse"); // [RL8]

  property p_stamp;
    @(posedge clk_i) disable iff (rst_i) trace_strobe_i |=> trace_valid_o && trace_stamp_o == $past(cnt_q);
  endproperty
  a_stamp: assert property (p_stamp) else $error("trace stamp wrong"); // [RL11]

  property p_slowest;
    @(posedge clk_i) disable iff (rst_i) (mode_q == 4'h9 || mode_q == 4'h4) |-> tb_idx == 3'h4;
  endproperty
  a_slowest: assert property (p_slowest) else $error("top setting not slowest base"); // [RL2]

  property p_fine_base;
    @(posedge clk_i) disable iff (rst_i) (mode_q == 4'h5) |-> tb_idx == 3'h0;
  endproperty
  a_fine_base: assert property (p_fine_base) else $error("setting 5 not on fastest base"); // [RL9]

  property p_us_base;
    @(posedge clk_i) disable iff (rst_i) (mode_q == 4'h1) |-> tb_idx == 3'h1;
  endproperty
  a_us_base: assert property (p_us_base) else $error("setting 1 not on microsecond base"); // [RL12]

endmodule // time_stamp_counter

// File: sim/trigger_source.sv
// Far-side model: event monitor trigger and two target interrupt lines
module trigger_source (
  input wire logic clk_i,
  output logic mon_o,
  output logic ext_n_o,
  output logic ext_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels; the low-active line rests high like a pulled-up interrupt
  initial
  begin
    mon_o = 1'b0;
    ext_n_o = 1'b1;
    ext_o = 1'b0;
  end

  // Asserts or releases one source right after an edge, then lets one edge pass
  task automatic drive(input int src, input logic on);
    case (src)
      0: ext_n_o <= ~on; // Low level asserts
      1: ext_o <= on; // High level asserts
      default: mon_o <= on;
    endcase
    @(posedge clk_i);
  endtask
endmodule // trigger_source

// File: sim/time_stamp_counter_tb.sv
// Self-checking bench of the time stamp counter over Wishbone and trigger lines
module time_stamp_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic trace_strobe_i = 1'b0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [7:0] trace_stamp_o;
  logic trace_valid_o;
  logic overflow_led_o;
  logic irq_o;
  logic mon;
  logic ext_n;
  logic ext;
  logic [31:0] rd;
  logic [3:0] bsel = 4'hF;
  int failures = 0;
  int check_count = 0;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  // Base 0 keeps its real 10 cycles; the slower bases are shortened, and an 8-bit counter keeps overflow in reach
  time_stamp_counter #(
    .CNT_W(8), .TB1_CYC(12), .TB2_CYC(14), .TB3_CYC(16), .TB4_CYC(18)
  ) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .monitor_trig_i(mon),
    .ext_trig_n_i(ext_n), .ext_trig_i(ext), .trace_strobe_i(trace_strobe_i),
    .trace_stamp_o(trace_stamp_o), .trace_valid_o(trace_valid_o),
    .overflow_led_o(overflow_led_o), .irq_o(irq_o)
  );

  trigger_source u_src (.clk_i(clk_i), .mon_o(mon), .ext_n_o(ext_n), .ext_o(ext));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Classic cycle; holds everything until ack is sampled, then idles one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= bsel;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    chk("ack_o", 32'h1, {31'h0, ack_o});
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, rd);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, rd);
    chk(what, exp, rd);
  endtask

  // One traced cycle: strobe taken at the next edge, stamp valid one cycle later
  task automatic trace(output logic [7:0] s);
    trace_strobe_i <= 1'b1;
    @(posedge clk_i);
    trace_strobe_i <= 1'b0;
    @(posedge clk_i);
    chk("trace_valid_o", 32'h1, {31'h0, trace_valid_o});
    s = trace_stamp_o;
  endtask

  // Two stamps exactly three tick periods apart differ by the expected step
  task automatic span(input int m, input logic [7:0] exp);
    int p;
    logic [7:0] a;
    logic [7:0] b;
    p = 10 + 2 * (m % 5);
    wr(8'h00, 32'(m));
    repeat (2 * p) @(posedge clk_i);
    trace(a);
    repeat (3 * p - 2) @(posedge clk_i);
    trace(b);
    chk("count step", {24'h0, exp}, {24'h0, b - a});
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    int i;
    logic [7:0] s0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc("ctrl", 8'h00, 32'h0);
    rdc("status", 8'h04, 32'h0);
    rdc("mask", 8'h08, 32'h0);
    wr(8'h10, 32'hFFFF_FFFF);
    rdc("unmapped", 8'h10, 32'h0);
    chk("overflow_led_o", 32'h0, {31'h0, overflow_led_o});
    $display("test reset done");
    // Every time base; gated settings see the trigger held, then released
    for (i = 0; i < 10; i++)
    begin
      if (i == 5) u_src.drive(2, 1'b1);
      span(i, 8'h3);
    end
    u_src.drive(2, 1'b0);
    span(9, 8'h0);
    $display("test time bases done");
    // Each source alone zeroes a running count in the slowest cleared setting
    wr(8'h00, 32'h4);
    for (i = 0; i < 3; i++)
    begin
      repeat (40) @(posedge clk_i);
      u_src.drive(i, 1'b1);
      trace(s0);
      chk("cleared stamp", 32'h0, {24'h0, s0});
      u_src.drive(i, 1'b0);
    end
    $display("test trigger clear done");
    // Pulse counting; the free-running time base must add nothing
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h1F);
    rdc("count after clear", 8'h0C, 32'h0);
    for (i = 0; i < 3; i++)
    begin
      u_src.drive(i, 1'b1);
      u_src.drive(i, 1'b0);
    end
    repeat (50) @(posedge clk_i);
    rdc("pulse count", 8'h0C, 32'h3);
    // Idle settings hold the count against both ticks and pulses
    wr(8'h00, 32'h1A);
    u_src.drive(2, 1'b1);
    u_src.drive(2, 1'b0);
    repeat (30) @(posedge clk_i);
    rdc("idle count", 8'h0C, 32'h0);
    $display("test pulse count done");
    // Sticky trigger event against the mask and its write-one clear
    rdc("status trig", 8'h04, 32'h2);
    chk("irq_o masked", 32'h0, {31'h0, irq_o});
    wr(8'h08, 32'h2);
    rdc("mask", 8'h08, 32'h2);
    chk("irq_o", 32'h1, {31'h0, irq_o});
    wr(8'h04, 32'h2);
    chk("irq_o cleared", 32'h0, {31'h0, irq_o});
    rdc("status cleared", 8'h04, 32'h0);
    // A write without the low byte lane selected must leave the mask alone
    bsel = 4'hE;
    wr(8'h08, 32'h1);
    bsel = 4'hF;
    rdc("mask lane off", 8'h08, 32'h2);
    $display("test interrupt done");
    // Wrap of the 8-bit count at the fastest base lights the indicator
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h10);
    repeat (2700) @(posedge clk_i);
    chk("overflow_led_o", 32'h1, {31'h0, overflow_led_o});
    chk("irq_o overflow", 32'h1, {31'h0, irq_o});
    wr(8'h04, 32'h1);
    chk("overflow_led_o cleared", 32'h0, {31'h0, overflow_led_o});
    $display("test overflow done");
    conclude();
  end

  // The run needs about 3800 cycles, most of it the 256-tick wrap; the limit leaves a wide margin
  initial
  begin
    #200000;
    failures++;
    conclude();
  end
endmodule // time_stamp_counter_tb
